// ### logic/fsdr_pkg.sv
// Package of constants and carrier types for the fault status register bank
`default_nettype none
package fsdr_pkg;
    // ------------------------------------------------------------
    // Register selects (local codes of the command decoder)
    // ------------------------------------------------------------
    localparam logic [1:0] FSDR_SEL_STATUS = 2'h0;
    localparam logic [1:0] FSDR_SEL_CHECK = 2'h1;
    localparam logic [1:0] FSDR_SEL_MASK1 = 2'h2;
    localparam logic [1:0] FSDR_SEL_NONE = 2'h3;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FSDR_BIT_DEADTIME = 4;
    localparam int FSDR_BIT_SER = 3;
    localparam int FSDR_BIT_REG = 2;
    localparam int FSDR_BIT_OV = 1;
    localparam int FSDR_BIT_UV = 0;
    localparam int FSDR_STAT_W = 5;
    localparam int FSDR_CHK_W = 5;
    localparam int FSDR_MASK_W = 8;
    // ------------------------------------------------------------
    // Power-up and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] FSDR_STAT_POWERUP = 5'h05;
    localparam logic [4:0] FSDR_STAT_RESET = 5'h00;
    localparam logic [4:0] FSDR_CHK_RESET = 5'h00;
    localparam logic [7:0] FSDR_MASK1_RESET = 8'hDA;
    localparam logic [7:0] FSDR_UNDEF_READ = 8'h00;

    // Fault events presented to the status block, one-cycle or level
    typedef struct packed {
        logic deadtime_violation;
        logic crc_fail;
        logic edge_count_fail;
        logic bad_command;
        logic bad_address;
        logic prog_fail;
        logic iso_link_fail;
        logic remote_change;
        logic prog_ok;
        logic supply_over;
        logic supply_under;
    } fsdr_event_t;

    // Other fault sources that feed the diagnostic pin
    typedef struct packed {
        logic thermal_warning;
        logic thermal_shutdown;
        logic short_feedback;
        logic sat_or_sense;
        logic overvoltage;
        logic undervoltage;
        logic remote_reg_error;
    } fsdr_ext_fault_t;

    // Host register access from the serial command decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [7:0] wdata;
    } fsdr_req_t;
endpackage : fsdr_pkg
`default_nettype wire

// ### logic/fsdr_sync2.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module fsdr_sync2 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync_out;

    always_comb begin
        next_stage1 = srst ? '0 : async_in;
        next_sync_out = srst ? '0 : stage1;
    end

    always_ff @(posedge clock) begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule : fsdr_sync2
`default_nettype wire

// ### logic/fsdr_fault_pin.sv
// Open-drain fault pin driver from mask and failure groups
`timescale 1ns/100ps
`default_nettype none
module fsdr_fault_pin
    import fsdr_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] mask,
    input wire logic [7:0] fail_group,
    output logic pin_oe,
    output logic pin_out
);
    logic next_pin_oe;

    always_comb begin
        next_pin_oe = srst ? 1'b0 : |(mask & fail_group);
    end

    always_ff @(posedge clock) begin
        pin_oe <= next_pin_oe;
        pin_out <= 1'b0;
    end
endmodule : fsdr_fault_pin
`default_nettype wire

// ### logic/fsdr_regs.sv
// Fault status, self-check control and fault pin mask register bank
`timescale 1ns/100ps
`default_nettype none
module fsdr_regs
    import fsdr_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic power_up,
    input wire fsdr_req_t req,
    input wire fsdr_event_t events,
    input wire fsdr_ext_fault_t ext_fault,
    input wire logic supply_over_pin,
    input wire logic supply_under_pin,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic safe_state,
    output logic sense_resistor_check_bit,
    output logic current_sense_comparator_check_bit,
    output logic saturation_detector_check_bit,
    output logic turnon_path_check_bit,
    output logic turnoff_path_check_bit,
    output logic fault_pin1_oe,
    output logic fault_pin1_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [FSDR_STAT_W-1:0] fault_status_three;
    logic [FSDR_STAT_W-1:0] next_fault_status_three;
    logic [FSDR_CHK_W-1:0] self_check_control;
    logic [FSDR_CHK_W-1:0] next_self_check_control;
    logic [FSDR_MASK_W-1:0] fault_pin1_mask;
    logic [FSDR_MASK_W-1:0] next_fault_pin1_mask;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_safe_state;
    logic [1:0] supply_sync;
    logic [7:0] fail_group;
    logic bad_access;
    logic deadtime_violation_flag;
    logic local_register_error_flag;
    logic logic_supply_overvoltage_flag;
    logic logic_supply_undervoltage_flag;

    // Supply comparators are analog, so they cross into the clock domain
    fsdr_sync2 #(
        .W(2)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .async_in({supply_over_pin, supply_under_pin}),
        .sync_out(supply_sync)
    );

    assign deadtime_violation_flag = fault_status_three[FSDR_BIT_DEADTIME];
    assign local_register_error_flag = fault_status_three[FSDR_BIT_REG];
    assign logic_supply_overvoltage_flag = fault_status_three[FSDR_BIT_OV];
    assign logic_supply_undervoltage_flag = fault_status_three[FSDR_BIT_UV];

    // Select decode, shared by the bad-access checks of writes and reads
    function automatic logic sel_valid(input logic [1:0] sel);
        sel_valid = (sel == FSDR_SEL_STATUS) || (sel == FSDR_SEL_CHECK)
            || (sel == FSDR_SEL_MASK1);
    endfunction : sel_valid

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_comb begin
        // bad address access flags serial error
        bad_access = (req.wr || req.rd) && !sel_valid(req.sel);
        // status is read-only, writing it is disallowed
        if (req.wr && req.sel == FSDR_SEL_STATUS) begin
            bad_access = 1'b1;
        end
        next_fault_status_three = fault_status_three;
        // correct programming releases error; set wins below
        if (events.prog_ok) begin
            next_fault_status_three[FSDR_BIT_REG] = 1'b0;
        end
        if (events.deadtime_violation) begin
            next_fault_status_three[FSDR_BIT_DEADTIME] = 1'b1;
        end
        if (events.crc_fail || events.edge_count_fail || bad_access
            || events.bad_command || events.bad_address) begin
            next_fault_status_three[FSDR_BIT_SER] = 1'b1;
        end
        if (events.prog_fail || events.iso_link_fail
            || events.remote_change) begin
            next_fault_status_three[FSDR_BIT_REG] = 1'b1;
        end
        if (events.supply_over || supply_sync[1]) begin
            next_fault_status_three[FSDR_BIT_OV] = 1'b1;
        end
        if (events.supply_under || supply_sync[0]) begin
            next_fault_status_three[FSDR_BIT_UV] = 1'b1;
        end
        if (srst) begin
            next_fault_status_three = FSDR_STAT_RESET;
        end
        if (power_up) begin
            next_fault_status_three = FSDR_STAT_POWERUP;
        end
    end

    always_ff @(posedge clock) begin
        fault_status_three <= next_fault_status_three;
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always_comb begin
        next_self_check_control = self_check_control;
        next_fault_pin1_mask = fault_pin1_mask;
        if (req.wr && req.sel == FSDR_SEL_CHECK) begin
            next_self_check_control = req.wdata[FSDR_CHK_W-1:0];
        end
        if (req.wr && req.sel == FSDR_SEL_MASK1) begin
            next_fault_pin1_mask = req.wdata;
        end
        if (srst || power_up) begin
            next_self_check_control = FSDR_CHK_RESET;
            next_fault_pin1_mask = FSDR_MASK1_RESET;
        end
    end

    always_ff @(posedge clock) begin
        self_check_control <= next_self_check_control;
        fault_pin1_mask <= next_fault_pin1_mask;
    end

    // ------------------------------------------------------------
    // Read path and outputs
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = FSDR_UNDEF_READ;
        next_rvalid = req.rd && !srst;
        if (req.rd) begin
            case (req.sel)
                FSDR_SEL_STATUS: next_rdata = {3'h0, fault_status_three};
                FSDR_SEL_CHECK: next_rdata = {3'h0, self_check_control};
                FSDR_SEL_MASK1: next_rdata = fault_pin1_mask;
                default: next_rdata = FSDR_UNDEF_READ;
            endcase
        end
        if (srst) begin
            next_rdata = FSDR_UNDEF_READ;
        end
        // safe state from register error and supply flags
        next_safe_state = next_fault_status_three[FSDR_BIT_REG]
            | next_fault_status_three[FSDR_BIT_OV]
            | next_fault_status_three[FSDR_BIT_UV];
    end

    always_ff @(posedge clock) begin
        rdata <= next_rdata;
        rvalid <= next_rvalid;
        safe_state <= next_safe_state;
        sense_resistor_check_bit <= next_self_check_control[0];
        current_sense_comparator_check_bit <= next_self_check_control[1];
        saturation_detector_check_bit <= next_self_check_control[2];
        turnon_path_check_bit <= next_self_check_control[3];
        turnoff_path_check_bit <= next_self_check_control[4];
    end

    // ------------------------------------------------------------
    // Fault pin one
    // ------------------------------------------------------------
    always_comb begin
        fail_group[0] = ext_fault.thermal_warning;
        fail_group[1] = ext_fault.thermal_shutdown;
        fail_group[2] = ext_fault.short_feedback | deadtime_violation_flag;
        fail_group[3] = ext_fault.sat_or_sense;
        fail_group[4] = ext_fault.overvoltage;
        fail_group[5] = ext_fault.undervoltage;
        fail_group[6] = logic_supply_overvoltage_flag
            | logic_supply_undervoltage_flag;
        fail_group[7] = fault_status_three[FSDR_BIT_SER]
            | local_register_error_flag | ext_fault.remote_reg_error;
    end

    // open drain asserts on enabled failure
    fsdr_fault_pin u_pin1 (
        .clock(clock),
        .srst(srst),
        .mask(fault_pin1_mask),
        .fail_group(fail_group),
        .pin_oe(fault_pin1_oe),
        .pin_out(fault_pin1_out)
    );
endmodule : fsdr_regs
`default_nettype wire

// ### dv/fsdr_regs_properties.sv
// Port timing checker of the fault status register bank
`timescale 1ns/100ps
`default_nettype none
module fsdr_regs_properties
    import fsdr_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic power_up,
    input wire fsdr_req_t req,
    input wire fsdr_event_t events,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic safe_state,
    input wire logic sense_resistor_check_bit,
    input wire logic turnoff_path_check_bit,
    input wire logic fault_pin1_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (srst || power_up);
    sequence s_read; req.rd && !req.wr; endsequence
    sequence s_stat_rd; s_read ##0 req.sel == FSDR_SEL_STATUS; endsequence
    sequence s_void_rd; s_read ##0 req.sel == FSDR_SEL_NONE; endsequence
    sequence s_chk_wr; req.wr && req.sel == FSDR_SEL_CHECK; endsequence
    chk_read_answer: assert property (s_read |=> rvalid)
        else $error("read not answered");
    chk_idle_quiet: assert property (!req.rd |=> !rvalid)
        else $error("answer without read");
    chk_status_pad: assert property (s_stat_rd |=> rdata[7:5] == 3'h0)
        else $error("status upper bits not zero");
    chk_void_read: assert property (s_void_rd |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_check_write: assert property (s_chk_wr |=>
        turnoff_path_check_bit == $past(req.wdata[4]) &&
        sense_resistor_check_bit == $past(req.wdata[0]))
        else $error("check bits not written");
    chk_over_safe: assert property (
        events.supply_over |=> safe_state)
        else $error("overvoltage without safe state");
    chk_under_safe: assert property (
        events.supply_under |=> safe_state)
        else $error("undervoltage without safe state");
    chk_regerr_safe: assert property (events.prog_fail |=> safe_state)
        else $error("register error without safe state");
    chk_safe_holds: assert property (
        safe_state && !events.prog_ok |=> safe_state)
        else $error("safe state dropped");
    chk_pin_low_only: assert property (fault_pin1_out == 1'b0)
        else $error("fault pin driven high");
endmodule : fsdr_regs_properties
`default_nettype wire

// ### dv/fsdr_host_model.sv
// Host model issuing register requests to the bank
`timescale 1ns/100ps
`default_nettype none
module fsdr_host_model
    import fsdr_pkg::*;
(
    input wire logic clock,
    input wire logic rvalid,
    input wire logic [7:0] rdata,
    output var fsdr_req_t req
);
    initial req = '0;
    task automatic access(input logic wr, input logic [1:0] sel,
        input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        @(negedge clock);
        req <= '{wr: wr, rd: !wr, sel: sel, wdata: wd};
        @(negedge clock);
        // Idle data flips so a stale word never looks fresh
        req <= '{wr: 1'b0, rd: 1'b0, sel: sel, wdata: ~wd};
        rd = 8'h00;
        ok = wr;
        // Answer stands one cycle only, so look at the falling edge inside it
        for (int n = 0; n < 4 && !ok; n++) begin
            if (rvalid === 1'b1) begin
                rd = rdata;
                ok = 1'b1;
            end else begin
                @(negedge clock);
            end
        end
    endtask : access
endmodule : fsdr_host_model
`default_nettype wire

// ### dv/test_fault_status_and_diag_regs.sv
// Self-checking bench of the fault status register bank
`timescale 1ns/100ps
`default_nettype none
module test_fault_status_and_diag_regs
    import fsdr_pkg::*;
;
    typedef struct packed {
        logic [10:0] ev;
        logic wr;
        logic [1:0] sel;
        logic [7:0] wd;
        logic [7:0] exp;
        logic safe;
    } fsdr_row_t;
    // ----------------------------------------
    // Rows: event, write, select, data, read, safe
    // ----------------------------------------
    localparam fsdr_row_t ROWS [14] = '{
        '{11'h400, 1'b0, 2'h0, 8'h00, 8'h10, 1'b0},
        '{11'h200, 1'b0, 2'h0, 8'h00, 8'h08, 1'b0},
        '{11'h100, 1'b0, 2'h0, 8'h00, 8'h08, 1'b0},
        '{11'h080, 1'b0, 2'h0, 8'h00, 8'h08, 1'b0},
        '{11'h040, 1'b0, 2'h0, 8'h00, 8'h08, 1'b0},
        '{11'h020, 1'b0, 2'h0, 8'h00, 8'h04, 1'b1},
        '{11'h010, 1'b0, 2'h0, 8'h00, 8'h04, 1'b1},
        '{11'h008, 1'b0, 2'h0, 8'h00, 8'h04, 1'b1},
        '{11'h002, 1'b0, 2'h0, 8'h00, 8'h02, 1'b1},
        '{11'h001, 1'b0, 2'h0, 8'h00, 8'h01, 1'b1},
        '{11'h000, 1'b1, 2'h1, 8'hEB, 8'h0B, 1'b0},
        '{11'h000, 1'b1, 2'h2, 8'h25, 8'h25, 1'b0},
        '{11'h000, 1'b1, 2'h0, 8'h1F, 8'h08, 1'b0},
        '{11'h000, 1'b0, 2'h3, 8'h00, 8'h00, 1'b0}};
    logic clock, srst, power_up, supply_over_pin, supply_under_pin;
    fsdr_req_t req;
    fsdr_event_t events;
    fsdr_ext_fault_t ext_fault;
    logic [7:0] rdata;
    logic [7:0] got;
    logic [4:0] chk;
    logic rvalid, safe_state, fault_pin1_oe, fault_pin1_out;
    int err_count = 0;
    int n_checks = 0;
    fsdr_regs fsdr_regs_inst (.clock(clock), .srst(srst),
        .power_up(power_up), .req(req), .events(events),
        .ext_fault(ext_fault), .supply_over_pin(supply_over_pin),
        .supply_under_pin(supply_under_pin), .rdata(rdata),
        .rvalid(rvalid), .safe_state(safe_state),
        .sense_resistor_check_bit(chk[0]),
        .current_sense_comparator_check_bit(chk[1]),
        .saturation_detector_check_bit(chk[2]),
        .turnon_path_check_bit(chk[3]), .turnoff_path_check_bit(chk[4]),
        .fault_pin1_oe(fault_pin1_oe), .fault_pin1_out(fault_pin1_out));
    fsdr_host_model fsdr_host_model_inst (.clock(clock), .rvalid(rvalid),
        .rdata(rdata), .req(req));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input string name, input logic [7:0] exp,
        input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : cmp
    task automatic host(input logic wr, input logic [1:0] sel,
        input logic [7:0] wd);
        logic ok;
        fsdr_host_model_inst.access(wr, sel, wd, got, ok);
        if (!ok) begin
            err_count++;
            end_of_test();
        end
    endtask : host
    task automatic pulse(input logic [10:0] ev, input int wait_n);
        @(negedge clock);
        events <= fsdr_event_t'(ev);
        @(negedge clock);
        events <= '0;
        repeat (wait_n) @(negedge clock);
    endtask : pulse
    task automatic do_reset();
        @(negedge clock);
        srst <= 1'b1;
        @(negedge clock);
        srst <= 1'b0;
    endtask : do_reset
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        srst = 1'b1;
        power_up = 1'b0;
        supply_over_pin = 1'b0;
        supply_under_pin = 1'b0;
        events = '0;
        ext_fault = '0;
        repeat (16) @(negedge clock);
        srst <= 1'b0;
        foreach (ROWS[i]) begin
            do_reset();
            pulse(ROWS[i].ev, 0);
            if (ROWS[i].wr) host(1'b1, ROWS[i].sel, ROWS[i].wd);
            host(1'b0, ROWS[i].sel, 8'h00);
            cmp("read", ROWS[i].exp, got);
            cmp("safe", {7'h0, ROWS[i].safe}, {7'h0, safe_state});
            if (ROWS[i].sel == FSDR_SEL_CHECK) begin
                cmp("chk", ROWS[i].exp, {3'h0, chk});
            end
            $display("row %0d done", i);
        end
        do_reset();
        host(1'b0, FSDR_SEL_STATUS, 8'h00);
        cmp("status", 8'h00, got);
        host(1'b0, FSDR_SEL_CHECK, 8'h00);
        cmp("check", 8'h00, got);
        host(1'b0, FSDR_SEL_MASK1, 8'h00);
        cmp("mask", 8'hDA, got);
        $display("reset test done");
        @(negedge clock);
        power_up <= 1'b1;
        @(negedge clock);
        power_up <= 1'b0;
        host(1'b0, FSDR_SEL_STATUS, 8'h00);
        cmp("powerup", 8'h05, got);
        pulse(11'h004, 0);
        host(1'b0, FSDR_SEL_STATUS, 8'h00);
        cmp("release", 8'h01, got);
        cmp("uv safe", 8'h01, {7'h0, safe_state});
        pulse(11'h024, 0);
        host(1'b0, FSDR_SEL_STATUS, 8'h00);
        cmp("set wins", 8'h05, got);
        $display("power-up test done");
        do_reset();
        supply_over_pin <= 1'b1;
        supply_under_pin <= 1'b1;
        repeat (6) @(negedge clock);
        supply_over_pin <= 1'b0;
        supply_under_pin <= 1'b0;
        repeat (4) @(negedge clock);
        host(1'b0, FSDR_SEL_STATUS, 8'h00);
        cmp("pins", 8'h03, got);
        $display("supply test done");
        // mask routes groups to the pin
        do_reset();
        ext_fault.thermal_warning <= 1'b1;
        repeat (3) @(negedge clock);
        cmp("oe warn", 8'h00, {7'h0, fault_pin1_oe});
        ext_fault.thermal_shutdown <= 1'b1;
        repeat (3) @(negedge clock);
        cmp("oe tsd", 8'h01, {7'h0, fault_pin1_oe});
        ext_fault <= '0;
        pulse(11'h400, 3);
        cmp("oe dt off", 8'h00, {7'h0, fault_pin1_oe});
        host(1'b1, FSDR_SEL_MASK1, 8'h04);
        repeat (2) @(negedge clock);
        cmp("oe dt on", 8'h01, {7'h0, fault_pin1_oe});
        host(1'b1, FSDR_SEL_MASK1, 8'h80);
        repeat (2) @(negedge clock);
        cmp("oe ser off", 8'h00, {7'h0, fault_pin1_oe});
        pulse(11'h080, 2);
        cmp("oe ser on", 8'h01, {7'h0, fault_pin1_oe});
        $display("pin test done");
        end_of_test();
    end
endmodule : test_fault_status_and_diag_regs
bind fsdr_regs fsdr_regs_properties fsdr_regs_properties_inst (
    .clock(clock), .srst(srst), .power_up(power_up), .req(req),
    .events(events), .rdata(rdata), .rvalid(rvalid),
    .safe_state(safe_state), .fault_pin1_out(fault_pin1_out),
    .sense_resistor_check_bit(sense_resistor_check_bit),
    .turnoff_path_check_bit(turnoff_path_check_bit));
`default_nettype wire
